// File: core/sleep_power_reset_control.sv
// Sleep, clock-gating, analog enable and reset control with an AHB-Lite
// register slave.
// Assumes one 50 MHz clock; all inputs but the reset source are on it.
`timescale 1ns/1ps
`include "spr_regs.svh"
module sleep_power_reset_control
   import spr_pkg::*;
#(
   parameter logic [15:0] STARTUP_CYC = 16'h0010,
   parameter logic [15:0] TOUT_SHORT_CYC = 16'h0010,
   parameter logic [15:0] TOUT_LONG_CYC = 16'h1000
)
(
   input wire logic CLOCK_I,
   input wire logic SYS_RST_I,
   input wire logic RST_SRC_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic [31:0] HRDATA_O,
   input wire logic SLEEP_EXEC_I,
   input wire logic WAKE_IRQ_I,
   input wire logic [1:0] BROWNOUT_THRESHOLD_FUSES_I,
   input wire logic [1:0] STARTUP_TIME_FUSES_I,
   input wire logic [1:0] CLOCK_SELECT_FUSES_I,
   input wire logic COMP_ON_I,
   input wire logic COMP_USES_REF_I,
   input wire logic ADC_ON_I,
   input wire logic ADC_CONV_START_I,
   input wire logic WDT_ON_I,
   input wire logic [5:0] WAKE_PIN_MASK_I,
   output logic CPU_CLK_EN_O,
   output logic FLASH_CLK_EN_O,
   output logic IO_CLK_EN_O,
   output logic ADC_CLK_EN_O,
   output logic TIMER_CLK_EN_O,
   output logic SLEEPING_O,
   output logic RESUME_O,
   output logic BOD_ENABLE_O,
   output logic REF_ENABLE_O,
   output logic COMP_ENABLE_O,
   output logic ADC_ENABLE_O,
   output logic ADC_EXTENDED_O,
   output logic WDT_RUN_O,
   output logic [5:0] INPUT_BUF_EN_O,
   output logic INT_RESET_O
);

   localparam logic [15:0] WAKE_HOLD_CYC = 16'(`WAKE_HALT_CYC + STARTUP_CYC);

   ctrl_state_t s_reg;
   ctrl_state_t s_next;
   logic int_rst;
   logic rst;
   logic brownout_sleep_disable_wr;
   logic brownout_sleep_disable_unlock;
   logic brownout_sleep_disable_set;
   logic brownout_sleep_disable_active;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] write_masked(input logic [7:0] old, input logic [7:0] wdata,
                                               input logic [7:0] mask);
      write_masked = (old & ~mask) | (wdata & mask);
   endfunction

   function automatic logic [31:0] read_reg(input logic [7:0] idx, input logic [7:0] cpc,
                                            input logic [7:0] pcg, input logic [7:0] did,
                                            input logic [7:0] bsc);
      case (idx)
         `CPC_IDX: read_reg = {24'h000000, cpc & `CPC_WMASK};
         `PCG_IDX: read_reg = {24'h000000, pcg & `PCG_WMASK};
         `DID_IDX: read_reg = {24'h000000, did & `DID_WMASK};
         `BSC_IDX: read_reg = {24'h000000, bsc};
         default: read_reg = 32'h00000000;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Reset stretch and disable sequencer
   // ----------------------------------------------------------------------
   reset_stretcher #(
      .TOUT_SHORT_CYC(TOUT_SHORT_CYC),
      .TOUT_LONG_CYC(TOUT_LONG_CYC)
   ) u_stretch (
      .clk_i(CLOCK_I),
      .sys_rst_i(SYS_RST_I),
      .src_rst_i(RST_SRC_I),
      .sut_i(STARTUP_TIME_FUSES_I),
      .clock_select_fuses_i(CLOCK_SELECT_FUSES_I),
      .hold_o(int_rst)
   );

   assign rst = SYS_RST_I | int_rst;
   assign brownout_sleep_disable_wr = s_reg.wr_pend && (s_reg.wr_idx == `BSC_IDX);

   brownout_sleep_disable_sequencer u_brownout_sleep_disable (
      .clk_i(CLOCK_I),
      .rst_i(rst),
      .wr_i(brownout_sleep_disable_wr),
      .disable_i(HWDATA_I[`BSC_DISABLE_BIT]),
      .unlock_i(HWDATA_I[`BSC_UNLOCK_BIT]),
      .unlock_o(brownout_sleep_disable_unlock),
      .set_o(brownout_sleep_disable_set),
      .active_o(brownout_sleep_disable_active)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic pd;
      logic io_on;
      logic adc_on;
      logic bod_on;
      pd = 1'b0;
      io_on = 1'b1;
      adc_on = 1'b1;
      bod_on = 1'b0;
      s_next = s_reg;
      s_next.resume = 1'b0;
      s_next.ready = 1'b1;
      s_next.resp = 1'b0;

      // Data phase of a pending write
      if (s_reg.wr_pend)
      begin
         case (s_reg.wr_idx)
            `CPC_IDX: s_next.cpc = write_masked(s_reg.cpc, HWDATA_I[7:0], `CPC_WMASK);
            `PCG_IDX: s_next.pcg = write_masked(s_reg.pcg, HWDATA_I[7:0], `PCG_WMASK);
            `DID_IDX: s_next.did = write_masked(s_reg.did, HWDATA_I[7:0], `DID_WMASK);
            default: s_next.cpc = s_reg.cpc;
         endcase
      end
      s_next.wr_pend = 1'b0;

      // Address phase; reads of CPC, PCG and DID see this cycle's write already applied
      if (HSEL_I && HTRANS_I[1] && HREADY_I)
      begin
         if (HWRITE_I)
         begin
            s_next.wr_pend = (HSIZE_I == `HSIZE_WORD);
            s_next.wr_idx = HADDR_I[9:2];
         end
         else
         begin
            s_next.rdata = read_reg(HADDR_I[9:2], s_next.cpc, s_next.pcg, s_next.did,
                                    {6'h00, brownout_sleep_disable_set, brownout_sleep_disable_unlock});
         end
      end

      // Sleep sequencing
      case (s_reg.state)
         ST_RUN:
         begin
            if (SLEEP_EXEC_I && s_reg.cpc[`SLEEP_ARM_BIT]
                && (s_reg.cpc[`SLEEP_MODE_HI:`SLEEP_MODE_LO] != `SM_RESERVED))
            begin
               s_next.state = ST_SLEEP;
               s_next.mode = s_reg.cpc[`SLEEP_MODE_HI:`SLEEP_MODE_LO];
               s_next.bod_off = brownout_sleep_disable_active;
            end
         end
         ST_SLEEP:
         begin
            if (WAKE_IRQ_I)
            begin
               s_next.state = ST_WAKE;
               s_next.wake_cnt = WAKE_HOLD_CYC - 16'h0001;
               s_next.bod_off = 1'b0;
            end
         end
         ST_WAKE:
         begin
            if (s_reg.wake_cnt == 16'h0000)
            begin
               s_next.state = ST_RUN;
               s_next.resume = 1'b1;
            end
            else
            begin
               s_next.wake_cnt = s_reg.wake_cnt - 16'h0001;
            end
         end
         default:
         begin
            s_next.state = ST_RUN;
         end
      endcase

      // Clock domains per sleep mode
      if (s_reg.state == ST_SLEEP)
      begin
         io_on = (s_reg.mode == `SM_IDLE);
         adc_on = (s_reg.mode != `SM_DOWN);
         pd = (s_reg.mode == `SM_DOWN);
      end
      s_next.cpu_en = (s_reg.state == ST_RUN);
      s_next.flash_en = (s_reg.state == ST_RUN);
      s_next.io_en = io_on;
      s_next.adc_clk_en = adc_on && !s_reg.pcg[`CONV_GATE_BIT];
      s_next.timer_en = io_on && !s_reg.pcg[`TIMER_GATE_BIT];
      s_next.sleeping = (s_reg.state != ST_RUN);

      // Analog enables
      bod_on = (BROWNOUT_THRESHOLD_FUSES_I != `BOD_FUSES_OFF) && !s_reg.bod_off;
      s_next.bod_en = bod_on;
      s_next.ref_en = bod_on || (COMP_ON_I && COMP_USES_REF_I) || ADC_ON_I;
      s_next.comp_en = COMP_ON_I && !s_reg.pcg[`CONV_GATE_BIT]
                       && !(pd && !COMP_USES_REF_I);
      s_next.adc_en = ADC_ON_I;
      s_next.wdt_run = WDT_ON_I;
      s_next.inbuf = pd ? WAKE_PIN_MASK_I : ~s_reg.did[5:0];

      // Extended conversion after re-enable; a new enable wins over the clear
      s_next.adc_prev = ADC_ON_I;
      if (ADC_ON_I && !s_reg.adc_prev)
      begin
         s_next.adc_ext = 1'b1;
      end
      else if (ADC_CONV_START_I)
      begin
         s_next.adc_ext = 1'b0;
      end

      if (rst)
      begin
         s_next = '0;
         s_next.cpc = `CPC_RESET;
         s_next.pcg = `PCG_RESET;
         s_next.did = `DID_RESET;
         s_next.ready = 1'b1;
         s_next.cpu_en = 1'b1;
         s_next.flash_en = 1'b1;
         s_next.io_en = 1'b1;
         s_next.adc_clk_en = 1'b1;
         s_next.timer_en = 1'b1;
         s_next.inbuf = 6'h3F;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      s_reg <= s_next;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign HREADYOUT_O = s_reg.ready;
   assign HRESP_O = s_reg.resp;
   assign HRDATA_O = s_reg.rdata;
   assign CPU_CLK_EN_O = s_reg.cpu_en;
   assign FLASH_CLK_EN_O = s_reg.flash_en;
   assign IO_CLK_EN_O = s_reg.io_en;
   assign ADC_CLK_EN_O = s_reg.adc_clk_en;
   assign TIMER_CLK_EN_O = s_reg.timer_en;
   assign SLEEPING_O = s_reg.sleeping;
   assign RESUME_O = s_reg.resume;
   assign BOD_ENABLE_O = s_reg.bod_en;
   assign REF_ENABLE_O = s_reg.ref_en;
   assign COMP_ENABLE_O = s_reg.comp_en;
   assign ADC_ENABLE_O = s_reg.adc_en;
   assign ADC_EXTENDED_O = s_reg.adc_ext;
   assign WDT_RUN_O = s_reg.wdt_run;
   assign INPUT_BUF_EN_O = s_reg.inbuf;
   assign INT_RESET_O = int_rst;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (rst);

   a_unarmed_sleep: assert property (
      (s_reg.state == ST_RUN && SLEEP_EXEC_I && !s_reg.cpc[`SLEEP_ARM_BIT]) |=> s_reg.state == ST_RUN)
      else $error("sleep entered while unarmed");

   a_idle_clocks: assert property (
      (s_reg.state == ST_SLEEP && s_reg.mode == `SM_IDLE) |=> (!CPU_CLK_EN_O && IO_CLK_EN_O))
      else $error("idle clocks wrong");

   a_down_clocks: assert property (
      (s_reg.state == ST_SLEEP && s_reg.mode == `SM_DOWN)
      |=> (!CPU_CLK_EN_O && !IO_CLK_EN_O && !ADC_CLK_EN_O && !TIMER_CLK_EN_O))
      else $error("power-down clocks still running");

   a_wake_hold: assert property (
      (s_reg.state == ST_SLEEP && WAKE_IRQ_I) |=> (s_reg.state == ST_WAKE && !RESUME_O) [*4])
      else $error("wake halt too short");

   a_timer_gate: assert property (
      s_reg.pcg[`TIMER_GATE_BIT] |=> !TIMER_CLK_EN_O)
      else $error("timer clock not gated");

   a_conv_gate: assert property (
      s_reg.pcg[`CONV_GATE_BIT] |=> (!ADC_CLK_EN_O && !COMP_ENABLE_O))
      else $error("converter gate ineffective");

   a_pd_comp: assert property (
      (s_reg.state == ST_SLEEP && s_reg.mode == `SM_DOWN && !COMP_USES_REF_I) |=> !COMP_ENABLE_O)
      else $error("comparator on in power-down");

   a_ref_kept: assert property (
      ((COMP_ON_I && COMP_USES_REF_I) || ADC_ON_I) |=> REF_ENABLE_O)
      else $error("reference dropped");

   a_gate_read: assert property (
      (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I && HADDR_I[9:2] == `PCG_IDX)
      |=> HRDATA_O[31:2] == 30'h00000000)
      else $error("reserved bits read nonzero");

   a_kept_running: assert property (
      (ADC_ON_I && WDT_ON_I) |=> (ADC_ENABLE_O && WDT_RUN_O))
      else $error("converter or watchdog stopped");

   a_bod_sleep: assert property (
      (s_reg.state == ST_RUN && !brownout_sleep_disable_active && BROWNOUT_THRESHOLD_FUSES_I != `BOD_FUSES_OFF)
      ##1 (s_reg.state == ST_SLEEP && $stable(BROWNOUT_THRESHOLD_FUSES_I)) |=> BOD_ENABLE_O)
      else $error("detector off without disable");

   c_idle: cover property (s_reg.state == ST_SLEEP && s_reg.mode == `SM_IDLE);
   c_noise: cover property (s_reg.state == ST_SLEEP && s_reg.mode == `SM_NOISE);
   c_down_bod_off: cover property (s_reg.state == ST_SLEEP && s_reg.mode == `SM_DOWN && s_reg.bod_off);
   c_resume: cover property (RESUME_O);

endmodule

// File: core/spr_regs.svh
// Register map, field positions, reset values and timing counts of the
// sleep, power and reset control block.
// Assumes inclusion by bare name from the core folder.
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CPC_IDX 8'h35
`define PCG_IDX 8'h25
`define BSC_IDX 8'h30
`define DID_IDX 8'h14

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define CPC_RESET 8'h00
`define PCG_RESET 8'h00
`define DID_RESET 8'h00
`define CPC_WMASK 8'h7B
`define PCG_WMASK 8'h03
`define DID_WMASK 8'h3F

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define SLEEP_ARM_BIT 5
`define SLEEP_MODE_HI 4
`define SLEEP_MODE_LO 3
`define TIMER_GATE_BIT 1
`define CONV_GATE_BIT 0
`define BSC_DISABLE_BIT 1
`define BSC_UNLOCK_BIT 0
`define SM_IDLE 2'h0
`define SM_NOISE 2'h1
`define SM_DOWN 2'h2
`define SM_RESERVED 2'h3
`define BOD_FUSES_OFF 2'h3
`define CLOCK_SELECT_FUSES_SLOW 2'h3
`define HSIZE_WORD 3'h2

// ----------------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------------
`define BROWNOUT_SLEEP_DISABLE_WINDOW_CYC 3'h4
`define BROWNOUT_SLEEP_DISABLE_ACT_CYC 2'h3
`define BROWNOUT_SLEEP_DISABLE_HOLD_CYC 2'h3
`define WAKE_HALT_CYC 16'h0004

`endif

// File: core/spr_pkg.sv
// Types shared by the sleep, power and reset control modules.
// Assumes nothing of its surroundings.
package spr_pkg;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} sleep_state_t;

   typedef struct packed {
      sleep_state_t state;
      logic [1:0] mode;
      logic bod_off;
      logic [15:0] wake_cnt;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic [7:0] cpc;
      logic [7:0] pcg;
      logic [7:0] did;
      logic adc_prev;
      logic adc_ext;
      logic cpu_en;
      logic flash_en;
      logic io_en;
      logic adc_clk_en;
      logic timer_en;
      logic sleeping;
      logic resume;
      logic bod_en;
      logic ref_en;
      logic comp_en;
      logic adc_en;
      logic wdt_run;
      logic [5:0] inbuf;
   } ctrl_state_t;

   typedef struct packed {
      logic [2:0] win;
      logic set;
      logic act;
      logic [1:0] cnt;
   } brownout_sleep_disable_state_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic hold;
      logic [15:0] cnt;
   } stretch_state_t;

endpackage

// File: core/brownout_sleep_disable_sequencer.sv
// Timed unlock and self-clearing brown-out-disable-in-sleep control.
// Assumes write pulses come from the register slave on the same clock.
`timescale 1ns/1ps
`include "spr_regs.svh"
module brownout_sleep_disable_sequencer
   import spr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic disable_i,
   input wire logic unlock_i,
   output logic unlock_o,
   output logic set_o,
   output logic active_o
);

   brownout_sleep_disable_state_t s_reg;
   brownout_sleep_disable_state_t s_next;

   always_comb
   begin
      s_next = s_reg;
      if (s_reg.win != 3'h0)
      begin
         s_next.win = s_reg.win - 3'h1;
      end
      if (wr_i)
      begin
         if (disable_i && unlock_i)
         begin
            s_next.win = `BROWNOUT_SLEEP_DISABLE_WINDOW_CYC;
         end
         else if ((s_reg.win != 3'h0) && disable_i && !unlock_i && !s_reg.set)
         begin
            s_next.win = 3'h0;
            s_next.set = 1'b1;
            s_next.cnt = `BROWNOUT_SLEEP_DISABLE_ACT_CYC;
         end
         else
         begin
            // Any other write closes the window
            s_next.win = 3'h0;
         end
      end
      if (s_reg.set)
      begin
         if (s_reg.cnt != 2'h1)
         begin
            s_next.cnt = s_reg.cnt - 2'h1;
         end
         else if (!s_reg.act)
         begin
            s_next.act = 1'b1;
            s_next.cnt = `BROWNOUT_SLEEP_DISABLE_HOLD_CYC;
         end
         else
         begin
            s_next.set = 1'b0;
            s_next.act = 1'b0;
            s_next.cnt = 2'h0;
         end
      end
      if (rst_i)
      begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      s_reg <= s_next;
   end

   assign unlock_o = (s_reg.win != 3'h0);
   assign set_o = s_reg.set;
   assign active_o = s_reg.act;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_brownout_sleep_disable_timing: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s_reg.set) |-> !s_reg.act [*3] ##1 s_reg.act [*3] ##1 !s_reg.set)
      else $error("disable bit timing wrong");

   a_brownout_sleep_disable_window: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && disable_i && !unlock_i && (s_reg.win == 3'h0)) |=> !$rose(s_reg.set))
      else $error("disable bit set without unlock");

   c_brownout_sleep_disable_active: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s_reg.act));

endmodule

// File: core/reset_stretcher.sv
// Reset source synchroniser and fuse-selected reset stretch counter.
// Assumes the reset source is asynchronous and fuses are static.
`timescale 1ns/1ps
`include "spr_regs.svh"
module reset_stretcher
   import spr_pkg::*;
#(
   parameter logic [15:0] TOUT_SHORT_CYC = 16'h0010,
   parameter logic [15:0] TOUT_LONG_CYC = 16'h1000
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic src_rst_i,
   input wire logic [1:0] sut_i,
   input wire logic [1:0] clock_select_fuses_i,
   output logic hold_o
);

   stretch_state_t s_reg;
   stretch_state_t s_next;

   // Longer start-up codes double the delay; slow clock uses the long base
   function automatic logic [15:0] select_timeout(input logic [1:0] startup_time_fuses, input logic [1:0] clock_select_fuses);
      logic [15:0] base;
      base = (clock_select_fuses == `CLOCK_SELECT_FUSES_SLOW) ? TOUT_LONG_CYC : TOUT_SHORT_CYC;
      select_timeout = base << startup_time_fuses;
   endfunction

   always_comb
   begin
      s_next = s_reg;
      s_next.sync1 = 1'b0;
      s_next.sync2 = s_reg.sync1;
      if (s_reg.sync2 || sys_rst_i)
      begin
         s_next.cnt = select_timeout(sut_i, clock_select_fuses_i);
      end
      else if (s_reg.cnt != 16'h0000)
      begin
         s_next.cnt = s_reg.cnt - 16'h0001;
      end
      s_next.hold = s_reg.sync2 || sys_rst_i || (s_reg.cnt != 16'h0000);
   end

   // Async set makes the port reset take effect with no clock running
   always_ff @(posedge clk_i or posedge src_rst_i)
   begin
      if (src_rst_i)
      begin
         s_reg <= '{sync1: 1'b1, sync2: 1'b1, hold: 1'b1, cnt: 16'h0000};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign hold_o = s_reg.hold;

endmodule

// File: bench/tb.sv
// Self-checking bench for the sleep, power and reset control block.
// Assumes the design files under core/ are compiled first; one 50 MHz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   import spr_pkg::*;
   typedef struct {logic [31:0] a; logic [7:0] wd; logic [7:0] ex;} row_t;
   logic clk = 1'b0, rst = 1'b1, rst_src = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic sleep_exec = 1'b0, wake_irq = 1'b0, comp_on = 1'b1, comp_ref = 1'b0, adc_on = 1'b0;
   logic conv_start = 1'b0, wdt_on = 1'b1, hresp, cpu_en, flash_en, io_en, adc_clk, tmr_clk;
   logic sleeping, resume, bod_en, ref_en, comp_en, adc_en, adc_ext, wdt_run, int_rst;
   logic [1:0] bod_fuse = 2'h0, clock_select_fuses = 2'h0;
   logic [5:0] inbuf, wake_mask = 6'h05;
   int bad_count = 0, n_tests = 0, n, m;
   row_t rows [4] = '{'{32'h000000D4, 8'hFF, 8'h7B}, '{32'h00000094, 8'hFF, 8'h03},
                      '{32'h00000050, 8'hFF, 8'h3F}, '{32'h000003FC, 8'hFF, 8'h00}};
   // Short counts keep the run brief: halt 4+4, time-out 4, long time-out 8
   sleep_power_reset_control #(.STARTUP_CYC(16'h0004), .TOUT_SHORT_CYC(16'h0004), .TOUT_LONG_CYC(16'h0008))
   sleep_power_reset_control_inst
   (
      .CLOCK_I(clk), .SYS_RST_I(rst), .RST_SRC_I(rst_src), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .SLEEP_EXEC_I(sleep_exec),
      .WAKE_IRQ_I(wake_irq), .BROWNOUT_THRESHOLD_FUSES_I(bod_fuse), .STARTUP_TIME_FUSES_I(2'h0),
      .CLOCK_SELECT_FUSES_I(clock_select_fuses), .COMP_ON_I(comp_on), .COMP_USES_REF_I(comp_ref), .ADC_ON_I(adc_on),
      .ADC_CONV_START_I(conv_start), .WDT_ON_I(wdt_on), .WAKE_PIN_MASK_I(wake_mask), .CPU_CLK_EN_O(cpu_en),
      .FLASH_CLK_EN_O(flash_en), .IO_CLK_EN_O(io_en), .ADC_CLK_EN_O(adc_clk), .TIMER_CLK_EN_O(tmr_clk),
      .SLEEPING_O(sleeping), .RESUME_O(resume), .BOD_ENABLE_O(bod_en), .REF_ENABLE_O(ref_en),
      .COMP_ENABLE_O(comp_en), .ADC_ENABLE_O(adc_en), .ADC_EXTENDED_O(adc_ext), .WDT_RUN_O(wdt_run),
      .INPUT_BUF_EN_O(inbuf), .INT_RESET_O(int_rst)
   );
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic end_of_test;
      if (bad_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // -------------------------------------------------------------------
   // Bus and stimulus helpers
   // -------------------------------------------------------------------
   // Address phase held until hready, then data phase held until hready
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h000000, wd};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] wd);
      logic [31:0] q;
      ahb(1'b1, a, wd, q);
   endtask
   task automatic pulse_sleep;
      @(posedge clk) sleep_exec <= 1'b1;
      @(posedge clk) sleep_exec <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Wake by interrupt; n counts cycles until the resume pulse
   task automatic wake;
      n = 0;
      @(posedge clk) wake_irq <= 1'b1;
      while (resume !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      wake_irq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic pause(input int c);
      repeat (c) @(posedge clk);
   endtask
   initial
   begin
      pause(6);
      rst <= 1'b0;
      while (int_rst !== 1'b0) @(posedge clk);
      `CHK({cpu_en, io_en, adc_clk, tmr_clk, inbuf, hready, hresp}, 12'hFFE)
      for (int i = 0; i < 3; i++)
      begin
         ahb(1'b0, rows[i].a, 8'h00, rd);
         `CHK(rd, 32'h0)
      end
      // ----------------------------------------------------------------
      // Register table: write all ones, read back masked
      // ----------------------------------------------------------------
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].wd);
         ahb(1'b0, rows[i].a, 8'h00, rd);
         `CHK(rd, {24'h0, rows[i].ex})
      end
      `CHK({tmr_clk, adc_clk, comp_en, inbuf}, 9'h000)
      wr(32'h94, 8'h00);
      wr(32'h50, 8'h00);
      pause(2);
      `CHK({tmr_clk, adc_clk, inbuf}, 8'hFF)
      adc_on <= 1'b1;
      pause(3);
      `CHK({adc_ext, ref_en}, 2'h3)
      @(posedge clk) conv_start <= 1'b1;
      @(posedge clk) conv_start <= 1'b0;
      pause(2);
      `CHK(adc_ext, 1'b0)
      // ----------------------------------------------------------------
      // Refused sleeps: unarmed, and reserved mode
      // ----------------------------------------------------------------
      wr(32'hD4, 8'h10);
      pulse_sleep();
      `CHK({sleeping, cpu_en}, 2'h1)
      wr(32'hD4, 8'h38);
      pulse_sleep();
      `CHK({sleeping, cpu_en}, 2'h1)
      // ----------------------------------------------------------------
      // Each sleep mode, then wake through the interrupt
      // ----------------------------------------------------------------
      for (m = 0; m < 3; m++)
      begin
         wr(32'hD4, 8'h20 | 8'(m << 3));
         pulse_sleep();
         `CHK({sleeping, cpu_en, flash_en, io_en, adc_clk}, {3'h4, m == 0, m != 2})
         `CHK({bod_en, wdt_run, adc_en, ref_en, comp_en}, {4'hF, m != 2})
         `CHK(inbuf, (m == 2) ? 6'h05 : 6'h3F)
         wake();
         // Irq taken, 4+4 halt cycles, resume pulse seen one edge late
         `CHK(n, 10)
         wr(32'hD4, 8'h00);
         `CHK({sleeping, cpu_en}, 2'h1)
      end
      // ----------------------------------------------------------------
      // Timed disable: lone write refused, full sequence honoured
      // ----------------------------------------------------------------
      wr(32'hC0, 8'h02);
      ahb(1'b0, 32'hC0, 8'h00, rd);
      `CHK(rd[1], 1'b0)
      wr(32'hD4, 8'h30);
      wr(32'hC0, 8'h03);
      wr(32'hC0, 8'h02);
      pause(4);
      pulse_sleep();
      `CHK({sleeping, bod_en}, 2'h2)
      wake();
      `CHK(bod_en, 1'b1)
      ahb(1'b0, 32'hC0, 8'h00, rd);
      `CHK(rd[1], 1'b0)
      bod_fuse <= 2'h3;
      adc_on <= 1'b0;
      pause(3);
      `CHK({bod_en, ref_en}, 2'h0)
      comp_ref <= 1'b1;
      wr(32'hD4, 8'h30);
      pulse_sleep();
      `CHK({ref_en, comp_en}, 2'h3)
      wake();
      // ----------------------------------------------------------------
      // Reset source: immediate hold, then stretched release
      // ----------------------------------------------------------------
      // Slow clock selection switches to the long time-out base
      clock_select_fuses <= 2'h3;
      @(posedge clk) rst_src <= 1'b1;
      #2;
      `CHK(int_rst, 1'b1)
      pause(3);
      rst_src <= 1'b0;
      n = 0;
      while (int_rst !== 1'b0 && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      // Two sync edges, eight time-out cycles, one to fall, one to be seen
      `CHK(n, 12)
      ahb(1'b0, 32'hD4, 8'h00, rd);
      `CHK(rd, 32'h0)
      end_of_test();
   end
   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
endmodule
